// ### hw/serial_rx_regs.svh
// Register map, field positions, reset values and timing counts for the serial
// receive status, data buffer and baud generator block.
// Assumes it is included by bare name by the package and the design module.
// Overview of operation
// - Break detection sets read-only break flag.
// - Break also sets framing error, receiver full.
// - Break in nine-bit mode clears ninth bit.
// - Break flag raises no interrupt.
// - Status-two read then data read clears break.
// - Break rearms only after line returns high.
// - Low at first sample slot sets progress.
// - Progress flag read-only, never interrupts.
// - False start or idle clears progress.
// - One data address: read rx, write tx.
// - Reset leaves data buffer contents alone.
// - One baud rate shared by rx, tx.
// - Prescaler codes give divisors 1,3,4,13.
// - Rate code gives divisor two to code.
// - Baud equals source over 64 times divisors.
// - Source is bus or crystal clock.
// - Zero stop bit flags framing error.
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define DATA_BUF_OFF 12'h018
`define STATUS_TWO_OFF 12'h01c
`define BAUD_SEL_OFF 12'h020
`define CONFIG_TWO_OFF 12'h024

// ****************************************************************
// Field positions.
// ****************************************************************
`define BREAK_BIT 1
`define PROGRESS_BIT 0
`define PRESCALE_LO 4
`define RATE_LO 0
`define SOURCE_BIT 0
`define NINE_BIT 1

// ****************************************************************
// Reset values and timing counts.
// ****************************************************************
`define BAUD_SEL_RST 8'h00
`define CONFIG_TWO_RST 8'h00
`define SRC_DIV_QUARTER 4
`define SLOTS_PER_BIT 16
`define SLOT_MID 4'h8
`define SLOT_LAST 4'hf
`define IDLE_BITS 4'ha

`endif

// ### hw/serial_rx_pkg.sv
// Types shared by the serial receive status block.
// Assumes the register header is on the include path.
package serial_rx_pkg;
    `include "serial_rx_regs.svh"

    // Receiver character states.
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } rx_state_t;
endpackage

// ### hw/serial_rx_status.sv
// Receive status two, data buffer and baud generator behind an APB slave.
// Assumes a single pclk domain; rxd and crystal_ref_clock are asynchronous pins.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "serial_rx_regs.svh"

module serial_rx_status
    import serial_rx_pkg::*;
(
    input wire logic pclk, // Bus clock, 125 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic rxd, // Receive data pin.
    input wire logic crystal_ref_clock, // Crystal reference, sampled.
    output logic baud_tick, // One pulse per bit time for the transmitter.
    output logic [7:0] tx_byte_bits, // Byte to transmit.
    output logic tx_load, // Pulse: new transmit byte written.
    output logic framing_error_set, // Pulse: set framing error flag.
    output logic rx_full_set, // Pulse: set receiver full flag.
    output logic rx_ninth_bit_clr, // Pulse: clear received ninth bit.
    output logic data_read_strobe // Pulse: data buffer was read.
);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic rxd_meta_ff, rxd_ff; // Receive pin synchroniser.
    logic xtal_meta_ff, xtal_ff, xtal_old_ff; // Crystal synchroniser and edge history.
    logic [7:0] baud_sel_ff; // Baud rate select register.
    logic [7:0] config_two_ff; // Source select and character length.
    logic [7:0] rx_byte_bits_ff; // Received byte, not reset.
    logic [7:0] tx_byte_ff; // Transmit byte, not reset.
    logic break_seen_flag_ff; // Break flag.
    logic rx_in_progress_flag_ff; // Reception in progress flag.
    logic break_armed_ff; // Status two read saw the break flag.
    logic rearm_ff; // Line has been high since the last break.
    logic [3:0] pre_cnt_ff; // Prescaler counter.
    logic [8:0] rate_cnt_ff; // Rate divisor counter.
    logic [3:0] slot_cnt_ff; // Sample slot within a bit.
    logic [3:0] tx_slot_ff; // Sample slots toward the next bit tick.
    logic [3:0] bit_idx_ff; // Data bit index.
    logic [3:0] idle_cnt_ff; // Consecutive high bit times.
    logic [8:0] shift_ff; // Receive shift register.
    logic all_zero_ff; // Every sampled bit so far was low.
    logic seen_high_ff; // Previous idle sample was high; a start needs a falling edge.
    logic [31:0] prdata_ff; // Registered read data.
    logic pslverr_ff; // Registered error answer.
    logic tx_load_ff, frame_err_set_ff, full_set_ff, ninth_clr_ff, rd_strobe_ff, baud_tick_ff;
    rx_state_t rx_state_ff;
    logic [3:0] prescale_divisor; // Decoded prescaler divisor.
    logic [8:0] rate_limit; // Four times the rate divisor, minus one.
    logic src_tick, slot_tick, access, mapped, rd_status, rd_data, wr_data;
    logic break_now, char_done, false_start, idle_seen;

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    // The access phase completes in one cycle; read data comes from a flop loaded at setup.
    assign pready = psel & penable;
    assign access = psel & penable;
    assign mapped = (paddr == `DATA_BUF_OFF) | (paddr == `STATUS_TWO_OFF) |
                    (paddr == `BAUD_SEL_OFF) | (paddr == `CONFIG_TWO_OFF);
    assign rd_status = access & ~pwrite & (paddr == `STATUS_TWO_OFF);
    assign rd_data = access & ~pwrite & (paddr == `DATA_BUF_OFF);
    assign wr_data = access & pwrite & (paddr == `DATA_BUF_OFF);
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff & access;

    // Read data and error are captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr_ff <= ~mapped;
            unique case (paddr)
                `DATA_BUF_OFF: prdata_ff <= {24'h00_0000, rx_byte_bits_ff};
                `STATUS_TWO_OFF: prdata_ff <= {30'h0000_0000, break_seen_flag_ff,
                                               rx_in_progress_flag_ff};
                `BAUD_SEL_OFF: prdata_ff <= {24'h00_0000, baud_sel_ff};
                `CONFIG_TWO_OFF: prdata_ff <= {24'h00_0000, config_two_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Writable registers; status two is read only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_sel_ff <= `BAUD_SEL_RST;
            config_two_ff <= `CONFIG_TWO_RST;
        end else if (access & pwrite) begin
            if (paddr == `BAUD_SEL_OFF) begin
                baud_sel_ff <= pwdata[7:0];
            end
            if (paddr == `CONFIG_TWO_OFF) begin
                config_two_ff <= pwdata[7:0];
            end
        end
    end

    // Data buffer halves keep their contents through reset.
    always_ff @(posedge pclk) begin
        if (wr_data) begin
            tx_byte_ff <= pwdata[7:0];
        end
        if (char_done) begin
            rx_byte_bits_ff <= shift_ff[7:0];
        end
    end

    // ****************************************************************
    // Input synchronisers.
    // ****************************************************************
    // Both pins pass two flops; logic never reads the first of them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_meta_ff <= 1'b1;
            rxd_ff <= 1'b1;
            xtal_meta_ff <= 1'b0;
            xtal_ff <= 1'b0;
            xtal_old_ff <= 1'b0;
        end else begin
            rxd_meta_ff <= rxd;
            rxd_ff <= rxd_meta_ff;
            xtal_meta_ff <= crystal_ref_clock;
            xtal_ff <= xtal_meta_ff;
            xtal_old_ff <= xtal_ff;
        end
    end

    // ****************************************************************
    // Baud generator.
    // ****************************************************************
    // The source is every bus clock or each rising crystal edge.
    assign src_tick = config_two_ff[`SOURCE_BIT] ? (xtal_ff & ~xtal_old_ff) : 1'b1;

    // Prescaler code decode.
    always_comb begin
        unique case (baud_sel_ff[`PRESCALE_LO +: 2])
            2'b00: prescale_divisor = 4'h1;
            2'b01: prescale_divisor = 4'h3;
            2'b10: prescale_divisor = 4'h4;
            2'b11: prescale_divisor = 4'hd;
        endcase
    end

    // Source over four times both divisors gives sixteen slots, so 64 per bit time.
    assign rate_limit = 9'((`SRC_DIV_QUARTER << baud_sel_ff[`RATE_LO +: 3]) - 1);
    assign slot_tick = src_tick & (pre_cnt_ff == prescale_divisor - 4'h1) &
                       (rate_cnt_ff == rate_limit);

    // Prescaler and rate counters run from the selected source.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_ff <= 4'h0;
            rate_cnt_ff <= 9'h000;
        end else if (src_tick) begin
            if (pre_cnt_ff >= prescale_divisor - 4'h1) begin
                pre_cnt_ff <= 4'h0;
                rate_cnt_ff <= (rate_cnt_ff >= rate_limit) ? 9'h000 : rate_cnt_ff + 9'h001;
            end else begin
                pre_cnt_ff <= pre_cnt_ff + 4'h1;
            end
        end
    end

    // One bit tick per sixteen slots, shared with the transmitter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_slot_ff <= 4'h0;
            baud_tick_ff <= 1'b0;
        end else begin
            if (slot_tick) begin
                tx_slot_ff <= tx_slot_ff + 4'h1;
            end
            baud_tick_ff <= slot_tick & (tx_slot_ff == `SLOT_LAST);
        end
    end

    // ****************************************************************
    // Receiver.
    // ****************************************************************
    assign false_start = slot_tick & (rx_state_ff == RX_START) &
                         (slot_cnt_ff == `SLOT_MID) & rxd_ff;
    assign char_done = slot_tick & (rx_state_ff == RX_STOP) & (slot_cnt_ff == `SLOT_MID);
    assign break_now = char_done & all_zero_ff & ~rxd_ff;
    assign idle_seen = slot_tick & (rx_state_ff == RX_IDLE) & (slot_cnt_ff == `SLOT_LAST) &
                       (idle_cnt_ff == `IDLE_BITS - 4'h1) & rxd_ff;

    // Character framing on sixteen sample slots per bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_ff <= RX_IDLE;
            slot_cnt_ff <= 4'h0;
            bit_idx_ff <= 4'h0;
            shift_ff <= 9'h000;
            all_zero_ff <= 1'b0;
            seen_high_ff <= 1'b0;
        end else if (slot_tick) begin
            slot_cnt_ff <= slot_cnt_ff + 4'h1;
            unique case (rx_state_ff)
                RX_IDLE: begin
                    seen_high_ff <= rxd_ff;
                    if (~rxd_ff & seen_high_ff) begin
                        rx_state_ff <= RX_START;
                        slot_cnt_ff <= 4'h2;
                        all_zero_ff <= 1'b1;
                    end
                end
                RX_START: begin
                    if (false_start) begin
                        rx_state_ff <= RX_IDLE;
                        slot_cnt_ff <= 4'h0;
                    end else if (slot_cnt_ff == `SLOT_LAST) begin
                        rx_state_ff <= RX_DATA;
                        bit_idx_ff <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (slot_cnt_ff == `SLOT_MID) begin
                        shift_ff[bit_idx_ff] <= rxd_ff;
                        all_zero_ff <= all_zero_ff & ~rxd_ff;
                    end
                    if (slot_cnt_ff == `SLOT_LAST) begin
                        bit_idx_ff <= bit_idx_ff + 4'h1;
                        if (bit_idx_ff == (config_two_ff[`NINE_BIT] ? 4'h8 : 4'h7)) begin
                            rx_state_ff <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (char_done) begin
                        rx_state_ff <= RX_IDLE;
                        slot_cnt_ff <= 4'h0;
                        seen_high_ff <= 1'b0; // A low stop bit is no falling edge.
                    end
                end
            endcase
        end
    end

    // Counts high bit times while idle to find an idle character.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_ff <= 4'h0;
        end else if (rx_state_ff != RX_IDLE || (slot_tick & ~rxd_ff)) begin
            idle_cnt_ff <= 4'h0;
        end else if (slot_tick && slot_cnt_ff == `SLOT_LAST && idle_cnt_ff < `IDLE_BITS) begin
            idle_cnt_ff <= idle_cnt_ff + 4'h1;
        end
    end

    // ****************************************************************
    // Flags and event pulses.
    // ****************************************************************
    // Progress flag; there is no interrupt path from it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_in_progress_flag_ff <= 1'b0;
        end else if (slot_tick & (rx_state_ff == RX_IDLE) & ~rxd_ff & seen_high_ff) begin
            rx_in_progress_flag_ff <= 1'b1;
        end else if (false_start | idle_seen | char_done) begin
            rx_in_progress_flag_ff <= 1'b0;
        end
    end

    // Break flag: set wins over the read-sequence clear; no interrupt output exists.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_seen_flag_ff <= 1'b0;
            break_armed_ff <= 1'b0;
            rearm_ff <= 1'b1;
        end else begin
            if (break_now & rearm_ff) begin
                break_seen_flag_ff <= 1'b1;
            end else if (rd_data & break_armed_ff) begin
                break_seen_flag_ff <= 1'b0;
            end
            if (rd_status) begin
                break_armed_ff <= break_seen_flag_ff;
            end else if (rd_data) begin
                break_armed_ff <= 1'b0;
            end
            if (break_now) begin
                rearm_ff <= 1'b0;
            end else if (rx_state_ff == RX_IDLE && rxd_ff) begin
                rearm_ff <= 1'b1;
            end
        end
    end

    // Registered one-cycle event pulses toward the status-one and transmit logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_err_set_ff <= 1'b0;
            full_set_ff <= 1'b0;
            ninth_clr_ff <= 1'b0;
            tx_load_ff <= 1'b0;
            rd_strobe_ff <= 1'b0;
        end else begin
            frame_err_set_ff <= char_done & ~rxd_ff;
            full_set_ff <= char_done;
            ninth_clr_ff <= break_now & config_two_ff[`NINE_BIT];
            tx_load_ff <= wr_data;
            rd_strobe_ff <= rd_data;
        end
    end

    assign baud_tick = baud_tick_ff;
    assign tx_byte_bits = tx_byte_ff;
    assign tx_load = tx_load_ff;
    assign framing_error_set = frame_err_set_ff;
    assign rx_full_set = full_set_ff;
    assign rx_ninth_bit_clr = ninth_clr_ff;
    assign data_read_strobe = rd_strobe_ff;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    brk_sets_flag_a: assert property (break_now & rearm_ff |=> break_seen_flag_ff)
        else $error("Break did not set the break flag.");
    brk_err_full_a: assert property (break_now |=> framing_error_set & rx_full_set)
        else $error("Break missed framing or full pulse.");
    brk_ninth_a: assert property (break_now & config_two_ff[`NINE_BIT] |=> rx_ninth_bit_clr)
        else $error("Break in nine-bit mode kept ninth bit.");
    brk_clear_a: assert property ($fell(break_seen_flag_ff) |->
        $past(rd_data & break_armed_ff))
        else $error("Break flag cleared without read sequence.");
    brk_rearm_a: assert property ($rose(break_seen_flag_ff) |-> $past(rearm_ff))
        else $error("Break flag set without line high.");
    rx_start_a: assert property ($rose(rx_in_progress_flag_ff) |->
        $past(~rxd_ff & slot_tick))
        else $error("Progress flag set without low sample.");
    rx_false_a: assert property (false_start |=> ~rx_in_progress_flag_ff)
        else $error("False start left progress flag set.");
    frame_stop_a: assert property (framing_error_set |-> $past(char_done & ~rxd_ff))
        else $error("Framing error without low stop bit.");
    tick_pace_a: assert property (slot_tick |=> ~slot_tick)
        else $error("Sample ticks on consecutive cycles.");
    pre_decode_a: assert property (baud_sel_ff[5:4] == 2'b11 |-> prescale_divisor == 4'hd)
        else $error("Prescaler code three not thirteen.");

    brk_cover_c: cover property (break_seen_flag_ff ##1 rd_status ##[1:20] rd_data);
    false_cover_c: cover property (false_start);
    char_cover_c: cover property (char_done & rxd_ff);
    xtal_cover_c: cover property (config_two_ff[`SOURCE_BIT] & slot_tick);

endmodule

`default_nettype wire

// ### tb/serial_line_partner.sv
// Behavioural far end of the receive line: a remote serial transmitter.
// Assumes its tasks are called right after a rising pclk edge.
`timescale 1ns/10ps
`default_nettype none

module serial_line_partner (
    input wire logic pclk, // Bus clock used to time bit periods.
    output logic rxd // Line towards the receiver, idle high.
);
    int bit_cyc = 64; // Bit time in pclk cycles.

    // The line idles at the mark level from time zero.
    initial begin
        rxd = 1'b1;
    end

    // Holds one line level for a number of cycles.
    task automatic hold(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge pclk);
    endtask

    // Sends a frame LSB first, one bit time per bit.
    task automatic send(input logic [10:0] f, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            hold(f[i], bit_cyc);
        end
    endtask
endmodule
`default_nettype wire

// ### tb/serial_rx_status_and_baud_gen_tb.sv
// Self-checking bench for the receive status, data buffer and baud generator.
// Assumes the partner model drives rxd; the APB task waits for pready.
`timescale 1ns/10ps
`default_nettype none
`include "serial_rx_regs.svh"

module serial_rx_status_and_baud_gen_tb;
    import serial_rx_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, rxd, xclk = 1'b0, baud_tick, tx_load;
    logic [7:0] tx_byte_bits, b;
    logic frame_set, full_set, r9_clr, rd_strobe;
    int err_count = 0, tests_run = 0, cyc = 0, seed = 72803, n, frame_n = 0, full_n = 0;
    int r9_n = 0, load_n = 0, rd_n = 0;
    int pre_div[4] = '{1, 3, 4, 13};
    logic [7:0] exp_q[$]; // Bytes the far end has sent and not yet read.

    // ****************************************************************
    // Clocks, instances and monitors.
    // ****************************************************************
    always #4 pclk = ~pclk;
    always #21 xclk = ~xclk; // Half period of 21 ns puts only every fourth of its edges on a pclk edge.

    serial_line_partner i_far (.pclk(pclk), .rxd(rxd));

    serial_rx_status i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .crystal_ref_clock(xclk), .baud_tick(baud_tick),
        .tx_byte_bits(tx_byte_bits), .tx_load(tx_load), .framing_error_set(frame_set),
        .rx_full_set(full_set), .rx_ninth_bit_clr(r9_clr), .data_read_strobe(rd_strobe));

    // Pulses are counted at the falling edge, where they are settled.
    always @(negedge pclk) begin
        frame_n += (frame_set === 1'b1);
        full_n += (full_set === 1'b1);
        r9_n += (r9_clr === 1'b1);
        load_n += (tx_load === 1'b1);
        rd_n += (rd_strobe === 1'b1);
    end

    // A hang counts as a mismatch.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            stop_test();
        end
    end

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the answer is taken as it stands at the ending edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles between two baud ticks.
    task automatic measure();
        @(negedge pclk);
        while (baud_tick !== 1'b1) @(negedge pclk);
        @(negedge pclk);
        n = 1;
        while (baud_tick !== 1'b1) begin
            n++;
            @(negedge pclk);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `BAUD_SEL_OFF, 0); check(r, 0);
        apb(1, `STATUS_TWO_OFF, 32'hff); apb(0, `STATUS_TWO_OFF, 0); check(r, 0);
        apb(0, 12'h030, 0); check({r[30:0], e}, 1);
        // Every prescaler code, then every rate code.
        for (int p = 0; p < 4; p++) begin
            apb(1, `BAUD_SEL_OFF, p << 4); measure(); check(n, 64 * pre_div[p]);
            apb(0, `BAUD_SEL_OFF, 0); check(r & 8'h37, p << 4);
        end
        for (int c = 0; c < 8; c++) begin
            apb(1, `BAUD_SEL_OFF, c); measure(); check(n, 64 << c);
        end
        apb(1, `BAUD_SEL_OFF, 0);
        // Random bytes received; progress shows within the start bit.
        repeat (3) begin
            b = $random(seed);
            exp_q.push_back(b);
            n = full_n;
            fork
                i_far.send({2'b11, b, 1'b0}, 10);
                begin repeat (16) @(posedge pclk); apb(0, `STATUS_TWO_OFF, 0); end
            join
            check(r[0], 1);
            check(full_n, n + 1);
            apb(0, `DATA_BUF_OFF, 0); check(r[7:0], exp_q.pop_front());
        end
        b = $random(seed);
        apb(1, `DATA_BUF_OFF, b); repeat (2) @(negedge pclk);
        check({tx_byte_bits, 24'(load_n)}, {b, 24'd1});
        check(rd_n, 3);
        // A low stop bit with data is a framing error, not a break.
        n = frame_n;
        i_far.send({2'b10, 8'h5a, 1'b0}, 10); i_far.hold(1'b1, 64);
        check(frame_n, n + 1);
        apb(0, `STATUS_TWO_OFF, 0); check(r[1], 0);
        apb(0, `DATA_BUF_OFF, 0);
        // A short low glitch starts and then drops a reception.
        i_far.hold(1'b0, 8); apb(0, `STATUS_TWO_OFF, 0); check(r[0], 1);
        i_far.hold(1'b1, 60); apb(0, `STATUS_TWO_OFF, 0); check(r[0], 0);
        // Break in nine-bit mode; the line then stays low.
        apb(1, `CONFIG_TWO_OFF, 2);
        n = frame_n + full_n + r9_n;
        i_far.send(11'h000, 11); i_far.hold(1'b0, 64);
        check(frame_n + full_n + r9_n, n + 3);
        apb(0, `DATA_BUF_OFF, 0); apb(0, `STATUS_TWO_OFF, 0); check(r[1], 1);
        apb(0, `DATA_BUF_OFF, 0); apb(0, `STATUS_TWO_OFF, 0); check(r[1], 0);
        i_far.hold(1'b0, 768); apb(0, `STATUS_TWO_OFF, 0); check(r[1], 0);
        i_far.hold(1'b1, 192); i_far.send(11'h000, 11); i_far.hold(1'b1, 64);
        apb(0, `STATUS_TWO_OFF, 0); check(r[1], 1);
        // Poll that no reception runs before the source is switched.
        apb(0, `STATUS_TWO_OFF, 0); check(r[0], 0);
        // Crystal source: 64 reference periods of 42 ns per bit.
        apb(1, `CONFIG_TWO_OFF, 1); measure(); measure();
        check(n >= 335 && n <= 337, 1);
        stop_test();
    end
endmodule
`default_nettype wire
